// ==== shared/ucc_pkg.sv ====
// Purpose: Constants for the serial channel control block
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes:   Register offsets are local choices
package ucc_pkg;
   localparam logic [3:0]  ADDR_CHANNEL_CONTROL = 4'h0;
   localparam logic [3:0]  ADDR_RATE_CONTROL    = 4'h4;
   localparam logic [3:0]  ADDR_STATUS          = 4'h8;
   localparam logic [15:0] CHANNEL_CONTROL_RST  = 16'h0000;
   localparam logic [15:0] RATE_CONTROL_RST     = 16'h003F;
   localparam logic [15:0] RATE_CONTROL_MASK    = 16'h2F3F;
   localparam int BIT_UNIT_ON      = 15;
   localparam int BIT_RECEIVE_ON   = 14;
   localparam int BIT_TRANSMIT_ON  = 13;
   localparam int BIT_SAMPLE_SEL   = 12;
   localparam int BIT_PARITY_ON    = 11;
   localparam int BIT_PARITY_SENSE = 10;
   localparam int BIT_TWO_STOP     = 9;
   localparam int BIT_CHAR_8       = 8;
   localparam int BIT_STALE_IRQ    = 7;
   localparam int BIT_FLOW_IRQ     = 6;
   localparam int BIT_RX_FULL_IRQ  = 5;
   localparam int BIT_RX_HALF_IRQ  = 4;
   localparam int BIT_RX_READY_IRQ = 3;
   localparam int BIT_TX_EMPTY_IRQ = 2;
   localparam int BIT_TX_HALF_IRQ  = 1;
   localparam int BIT_TX_SLOT_IRQ  = 0;
   localparam int BIT_CLK_DIR      = 13;
   localparam int BIT_BAUD_SRC     = 11;
   localparam int DIV_HI           = 10;
   localparam int DIV_LO           = 8;
   localparam int PRE_HI           = 5;
   localparam logic [6:0] PRESCALE_BASE = 7'd65;
   localparam logic [2:0] DIV_MAX_CODE  = 3'h5;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage : ucc_pkg

// ==== rtl/ucc_channel_control.sv ====
// Purpose: Control register, rate generator and interrupt gating for a serial channel
// Assumes: FIFO levels and stale flag come from same-clock logic
// Notes:   Pins pass two flip-flops before use
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
module ucc_channel_control (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   // AXI4-Lite write address, data and response
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // FIFO and receiver status
   input  wire logic        rx_fifo_full,
   input  wire logic        rx_fifo_over_half,
   input  wire logic        rx_fifo_not_empty,
   input  wire logic        stale_data_flag,
   input  wire logic        tx_fifo_empty,
   input  wire logic        tx_fifo_under_half,
   input  wire logic        tx_fifo_not_full,
   // Pins
   input  wire logic        clear_to_send_in,
   input  wire logic        oversample_clock,
   input  wire logic        ext_bit_clock_in,
   output logic             ext_bit_clock_out,
   output logic             ext_bit_clock_oe,
   // Channel controls
   output logic             receiver_enable,
   output logic             transmitter_enable,
   output logic             rx_fifo_flush,
   output logic             tx_fifo_flush,
   output logic             rx_sample_tick,
   output logic             bit_clock_tick,
   output logic             parity_on,
   output logic             parity_odd,
   output logic             two_stop_bits,
   output logic             char_8bit,
   output logic             irq
);
   logic [15:0] channel_control;
   logic [15:0] rate_control;
   logic [15:0] wr_word;
   logic        aw_held;
   logic        w_held;
   logic [3:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic [1:0]  cts_sync;
   logic        cts_last;
   logic        cts_changed;
   logic [1:0]  osc_sync;
   logic        osc_last;
   logic [1:0]  ext_sync;
   logic        ext_last;
   logic        src_tick;
   logic [6:0]  pre_cnt;
   logic        pre_tick;
   logic [4:0]  div_cnt;
   logic        baud_tick;
   logic [3:0]  os_cnt;
   logic        start_seen;
   logic [6:0]  pre_target;
   logic [4:0]  div_target;
   logic [7:0]  conditions;
   logic [7:0]  enables;

   function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old_v[15:8], s[0] ? d[7:0] : old_v[7:0]};
   endfunction : merge

   // Write channel capture, either order
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 4'h0;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (aw_held && w_held) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (aw_held && w_held) begin
            w_held <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ucc_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (aw_held && w_held) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == ucc_pkg::ADDR_CHANNEL_CONTROL ||
                             aw_addr == ucc_pkg::ADDR_RATE_CONTROL ||
                             aw_addr == ucc_pkg::ADDR_STATUS) ?
                            ucc_pkg::RESP_OKAY : ucc_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         channel_control <= ucc_pkg::CHANNEL_CONTROL_RST;
         rate_control    <= ucc_pkg::RATE_CONTROL_RST;
      end else if (clk_en && aw_held && w_held) begin
         if (aw_addr == ucc_pkg::ADDR_CHANNEL_CONTROL) begin
            channel_control <= merge(channel_control, w_data, w_strb);
         end
         if (aw_addr == ucc_pkg::ADDR_RATE_CONTROL) begin
            rate_control <= merge(rate_control, w_data, w_strb) & ucc_pkg::RATE_CONTROL_MASK;
         end
      end
   end

   assign wr_word = 16'h0000;

   // Read channel
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= ucc_pkg::RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ucc_pkg::RESP_OKAY;
            case (s_axi_araddr)
               ucc_pkg::ADDR_CHANNEL_CONTROL: s_axi_rdata <= {wr_word, channel_control};
               ucc_pkg::ADDR_RATE_CONTROL:    s_axi_rdata <= {wr_word, rate_control};
               ucc_pkg::ADDR_STATUS:          s_axi_rdata <= {wr_word, 7'h00, irq, conditions};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= ucc_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         // Flow pin idles high, so no false change after reset
         cts_sync <= 2'b11;
         osc_sync <= 2'b00;
         ext_sync <= 2'b00;
         cts_last <= 1'b1;
         osc_last <= 1'b0;
         ext_last <= 1'b0;
      end else if (clk_en) begin
         cts_sync <= {cts_sync[0], clear_to_send_in};
         osc_sync <= {osc_sync[0], oversample_clock};
         ext_sync <= {ext_sync[0], ext_bit_clock_in};
         cts_last <= cts_sync[1];
         osc_last <= osc_sync[1];
         ext_last <= ext_sync[1];
      end
   end

   assign receiver_enable    = channel_control[ucc_pkg::BIT_UNIT_ON] &&
                               channel_control[ucc_pkg::BIT_RECEIVE_ON];
   assign transmitter_enable = channel_control[ucc_pkg::BIT_UNIT_ON] &&
                               channel_control[ucc_pkg::BIT_TRANSMIT_ON];
   assign rx_fifo_flush = !receiver_enable;
   assign tx_fifo_flush = !transmitter_enable;
   assign parity_on     = channel_control[ucc_pkg::BIT_PARITY_ON];
   assign parity_odd    = parity_on && channel_control[ucc_pkg::BIT_PARITY_SENSE];
   assign two_stop_bits = channel_control[ucc_pkg::BIT_TWO_STOP];
   assign char_8bit     = channel_control[ucc_pkg::BIT_CHAR_8];

   assign src_tick = rate_control[ucc_pkg::BIT_BAUD_SRC] ? (ext_sync[1] && !ext_last) : 1'b1;
   assign pre_target = ucc_pkg::PRESCALE_BASE - 7'(rate_control[ucc_pkg::PRE_HI:0]) - 7'h01;
   always_comb begin
      case (rate_control[ucc_pkg::DIV_HI:ucc_pkg::DIV_LO])
         3'h0: div_target = 5'd0;
         3'h1: div_target = 5'd1;
         3'h2: div_target = 5'd3;
         3'h3: div_target = 5'd7;
         3'h4: div_target = 5'd15;
         default: div_target = 5'd31;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pre_cnt   <= 7'h00;
         pre_tick  <= 1'b0;
         div_cnt   <= 5'h00;
         baud_tick <= 1'b0;
      end else if (clk_en) begin
         pre_tick  <= 1'b0;
         baud_tick <= 1'b0;
         if (src_tick) begin
            if (pre_cnt >= pre_target) begin
               pre_cnt  <= 7'h00;
               pre_tick <= 1'b1;
            end else begin
               pre_cnt <= pre_cnt + 7'h01;
            end
         end
         if (pre_tick) begin
            if (div_cnt >= div_target) begin
               div_cnt   <= 5'h00;
               baud_tick <= 1'b1;
            end else begin
               div_cnt <= div_cnt + 5'd1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         os_cnt     <= 4'h0;
         start_seen <= 1'b0;
         rx_sample_tick <= 1'b0;
      end else if (clk_en) begin
         rx_sample_tick <= 1'b0;
         if (channel_control[ucc_pkg::BIT_SAMPLE_SEL]) begin
            rx_sample_tick <= receiver_enable && osc_sync[1] && !osc_last;
            os_cnt         <= 4'h0;
            start_seen     <= 1'b0;
         end else if (!receiver_enable) begin
            os_cnt     <= 4'h0;
            start_seen <= 1'b0;
         end else if (baud_tick) begin
            start_seen <= 1'b1;
            os_cnt     <= start_seen ? os_cnt + 4'd1 : 4'h0;
            rx_sample_tick <= start_seen && (os_cnt == 4'h7);
         end
      end
   end

   assign bit_clock_tick    = baud_tick;
   assign ext_bit_clock_oe  = rate_control[ucc_pkg::BIT_CLK_DIR];
   assign ext_bit_clock_out = div_cnt[0];

   // flow pin change capture, set wins
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cts_changed <= 1'b0;
      end else if (clk_en) begin
         if (cts_sync[1] != cts_last) begin
            cts_changed <= 1'b1;
         end else if (!channel_control[ucc_pkg::BIT_FLOW_IRQ]) begin
            cts_changed <= 1'b0;
         end
      end
   end

   assign conditions = {stale_data_flag, cts_changed, rx_fifo_full, rx_fifo_over_half,
                        rx_fifo_not_empty, tx_fifo_empty, tx_fifo_under_half,
                        tx_fifo_not_full};
   assign enables    = channel_control[ucc_pkg::BIT_STALE_IRQ:ucc_pkg::BIT_TX_SLOT_IRQ];

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= channel_control[ucc_pkg::BIT_UNIT_ON] && |(conditions & enables);
      end
   end
endmodule : ucc_channel_control

// ==== tb/ucc_checker.sv ====
// Purpose: Port checks for the channel control block
// Assumes: Sees only the top module ports
// Notes:   Bound at the foot of this file
module ucc_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Channel outputs
   input wire logic receiver_enable,
   input wire logic transmitter_enable,
   input wire logic rx_fifo_flush,
   input wire logic tx_fifo_flush,
   input wire logic parity_on,
   input wire logic parity_odd,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_rx_flush; rx_fifo_flush == !receiver_enable; endproperty
   a_rx_flush: assert property (p_rx_flush) else $error("rx flush wrong");
   property p_tx_flush; tx_fifo_flush == !transmitter_enable; endproperty
   a_tx_flush: assert property (p_tx_flush) else $error("tx flush wrong");
   property p_odd; parity_odd |-> parity_on; endproperty
   a_odd: assert property (p_odd) else $error("odd without parity");
   property p_w_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid; endproperty
   a_w_ans: assert property (p_w_ans) else $error("no write answer");
   property p_r_ans; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("no read answer");
   property p_w_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_w_ref: assert property (p_w_ref) else $error("write taken early");
   property p_r_ref; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_ref: assert property (p_r_ref) else $error("read taken early");
   property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_end: assert property (p_b_end) else $error("bvalid stuck");
   property p_r_end; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_end: assert property (p_r_end) else $error("rvalid stuck");
   property p_freeze;
      !clk_en |=> $stable(irq) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_irq: cover property ($rose(irq));
endmodule : ucc_checker

bind ucc_channel_control ucc_checker i_ucc_checker (.*);

// ==== tb/ucc_far_model.sv ====
// Purpose: Far side: FIFO fill flags and remote serial pins
// Assumes: FIFO depth is a plain parameter
// Notes:   Pins stand still outside clock bursts and flow pin flips
module ucc_far_model #(
   parameter int DEPTH = 8
) (
   // Fill levels from the bench
   input wire logic [3:0] rx_cnt,
   input wire logic [3:0] tx_cnt,
   // Status flags
   output logic           rx_fifo_full,
   output logic           rx_fifo_over_half,
   output logic           rx_fifo_not_empty,
   output logic           tx_fifo_empty,
   output logic           tx_fifo_under_half,
   output logic           tx_fifo_not_full,
   // Pins
   output logic           clear_to_send_in,
   output logic           oversample_clock
);
   timeunit 1ns;
   timeprecision 1ns;
   assign rx_fifo_full = rx_cnt == 4'(DEPTH);
   assign rx_fifo_over_half = rx_cnt > 4'(DEPTH / 2);
   assign rx_fifo_not_empty = rx_cnt != 4'h0;
   assign tx_fifo_empty = tx_cnt == 4'h0;
   assign tx_fifo_under_half = tx_cnt < 4'(DEPTH / 2);
   assign tx_fifo_not_full = tx_cnt != 4'(DEPTH);
   initial begin
      clear_to_send_in = 1'b1;
      oversample_clock = 1'b0;
   end
   task automatic clk_burst(input int n);
      repeat (n) begin
         #130 oversample_clock = 1'b1;
         #130 oversample_clock = 1'b0;
      end
   endtask : clk_burst
   task automatic flip_cts();
      #70 clear_to_send_in = ~clear_to_send_in;
   endtask : flip_cts
endmodule : ucc_far_model

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the channel control block
// Assumes: Far-side model supplies FIFO flags, flow pin and oversample clock
// Notes:   Random control words from a fixed seed
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int D = 8;
   localparam logic [3:0] CC = ucc_pkg::ADDR_CHANNEL_CONTROL;
   localparam logic [3:0] RC = ucc_pkg::ADDR_RATE_CONTROL;
   localparam logic [1:0] OK = ucc_pkg::RESP_OKAY;
   logic core_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, ext_bit_clock_in = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, stale_data_flag = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [3:0] rx_cnt = 4'h0, tx_cnt = 4'h8;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rx_fifo_full, rx_fifo_over_half, rx_fifo_not_empty, tx_fifo_empty;
   logic tx_fifo_under_half, tx_fifo_not_full, clear_to_send_in, oversample_clock;
   logic ext_bit_clock_out, ext_bit_clock_oe, receiver_enable, transmitter_enable;
   logic rx_fifo_flush, tx_fifo_flush, rx_sample_tick, bit_clock_tick;
   logic parity_on, parity_odd, two_stop_bits, char_8bit, irq;
   int mismatches = 0, checks = 0, ticks = 0;
   ucc_channel_control i_ucc_channel_control (.*);
   ucc_far_model #(.DEPTH(D)) i_ucc_far_model (.*);
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) if (rx_sample_tick === 1'b1) ticks <= ticks + 1;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (pa || pw) begin
         @(posedge core_clk);
         if (pa && s_axi_awready === 1'b1) begin
            s_axi_awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pw && s_axi_wready === 1'b1) begin
            s_axi_wvalid <= 1'b0;
            pw = 1'b0;
         end
      end
      do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
      chk("bresp", 32'(OK), 32'(s_axi_bresp));
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'(r), 32'(s_axi_rresp));
   endtask : rd
   task automatic period(input logic [15:0] r, output int p);
      wr(RC, 32'(r), 4'hF);
      repeat (2) do @(posedge core_clk); while (bit_clock_tick !== 1'b1);
      p = 0;
      do begin
         @(posedge core_clk);
         p++;
      end while (bit_clock_tick !== 1'b1);
      chk("clk_out", 32'h0, 32'(ext_bit_clock_out));
   endtask : period
   function automatic logic [7:0] conds(input int r, input int t, input logic s);
      return {s, 1'b0, r == D, r > D / 2, r != 0, t == 0, t < D / 2, t != D};
   endfunction : conds
   function automatic logic exp_irq(input logic [15:0] c, input logic [7:0] v);
      return c[15] & (|(c[7:0] & v));
   endfunction : exp_irq
   task automatic final_report();
      $display("Checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   initial begin
      #2000000;
      mismatches++;
      final_report();
   end
   initial begin
      logic [15:0] c;
      int rc, tc, pa, pb, pc, pe, n;
      logic st;
      void'($urandom(32'hAAACCF8F));
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      chk("flush", 32'h3, 32'({rx_fifo_flush, tx_fifo_flush}));
      rd(CC, 32'h0, OK);
      rd(RC, 32'h3F, OK);
      rd(4'hC, 32'h0, ucc_pkg::RESP_SLVERR);
      wr(CC, 32'hFFFF, 4'h1);
      rd(CC, 32'hFF, OK);
      wr(CC, 32'hC000, 4'hF);
      for (int i = 0; i < 30; i++) begin
         c = (i == 0) ? 16'h7FBF : 16'($urandom) & 16'hFFBF;
         rc = (i == 0) ? D : $urandom_range(D);
         tc = (i == 0) ? 0 : $urandom_range(D);
         st = (i == 0) ? 1'b1 : 1'($urandom);
         rx_cnt <= 4'(rc);
         tx_cnt <= 4'(tc);
         stale_data_flag <= st;
         wr(CC, 32'(c), 4'hF);
         rd(CC, 32'(c), OK);
         chk("irq", 32'(exp_irq(c, conds(rc, tc, st))), 32'(irq));
         rd(ucc_pkg::ADDR_STATUS, 32'({exp_irq(c, conds(rc, tc, st)), conds(rc, tc, st)}), OK);
         chk("rx_en", 32'(c[15] & c[14]), 32'(receiver_enable));
         chk("tx_en", 32'(c[15] & c[13]), 32'(transmitter_enable));
         chk("parity", 32'({c[11], c[11] & c[10]}), 32'({parity_on, parity_odd}));
         chk("format", 32'(c[9:8]), 32'({two_stop_bits, char_8bit}));
      end
      rx_cnt <= 4'h0;
      tx_cnt <= 4'(D);
      stale_data_flag <= 1'b0;
      wr(CC, 32'h8040, 4'hF);
      chk("irq", 32'h0, 32'(irq));
      clk_en <= 1'b0;
      i_ucc_far_model.flip_cts();
      repeat (6) @(posedge core_clk);
      chk("irq_frozen", 32'h0, 32'(irq));
      clk_en <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("irq", 32'h1, 32'(irq));
      wr(CC, 32'h8000, 4'hF);
      repeat (2) @(posedge core_clk);
      chk("irq", 32'h0, 32'(irq));
      wr(CC, 32'hD000, 4'hF);
      repeat (4) @(posedge core_clk);
      ticks = 0;
      i_ucc_far_model.clk_burst(8);
      repeat (8) @(posedge core_clk);
      chk("ticks", 32'd8, 32'(ticks));
      wr(CC, 32'hC000, 4'hF);
      repeat (3) begin
         c = 16'($urandom);
         wr(RC, 32'(c), 4'hF);
         rd(RC, 32'(c & ucc_pkg::RATE_CONTROL_MASK), OK);
         chk("clk_oe", 32'(c[13]), 32'(ext_bit_clock_oe));
      end
      period(16'h003F, pa);
      chk("period", 32'(ucc_pkg::PRESCALE_BASE - 7'h3F), 32'(pa));
      n = 0;
      repeat (320) begin
         @(posedge core_clk);
         if (rx_sample_tick === 1'b1) n++;
      end
      chk("ticks16", 32'd10, 32'(n));
      period(16'h013D, pb);
      chk("ratio", 32'(4 * pa), 32'(pb));
      fork
         period(16'h083F, pe);
         repeat (200) begin
            repeat (2) @(posedge core_clk);
            ext_bit_clock_in <= ~ext_bit_clock_in;
         end
      join
      chk("ext_period", 32'(4 * (ucc_pkg::PRESCALE_BASE - 7'h3F)), 32'(pe));
      period(16'h0500, pc);
      chk("period_max", 32'(32 * ucc_pkg::PRESCALE_BASE), 32'(pc));
      final_report();
   end
endmodule : tb_top
